// ==== core/ubs_pkg.sv ====
// Package of constants and types for the bridged serial port
package ubs_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int BAUD_MIN = 300;
  localparam int BAUD_MAX = 6000000;
  localparam int BAUD_DEF = 9600;
  localparam int DIV_W = 20;
  localparam logic [19:0] DIV_MIN = 20'(CLK_HZ / BAUD_MAX);
  localparam logic [19:0] DIV_MAX = 20'(CLK_HZ / BAUD_MIN);
  localparam logic [19:0] DIV_DEF = 20'(CLK_HZ / BAUD_DEF);
  localparam logic FLOW_DEF = 1'b1;
  localparam logic BITS8_DEF = 1'b1;
  localparam logic PAR_EN_DEF = 1'b0;
  localparam logic PAR_ODD_DEF = 1'b0;
  localparam logic STOP2_DEF = 1'b0;
  localparam logic [2:0] SEL_SERIAL = 3'h1;
  typedef enum logic [2:0] {
    UBS_IDLE, UBS_START, UBS_DATA, UBS_PAR, UBS_STOP
  } ubs_state_e;
endpackage

// ==== core/ubs_port.sv ====
// Bridged serial port: line format, flow control, link gating
//
// Functional notes
// R01: Bit rate programmable from 300 to 6M baud
// R02: Frame: start bit, 7/8 data, optional parity
// R03: One or two stop bits close each frame
// R04: Transmit data least significant bit first
// R05: Line format set by host link only
// R06: Default bit rate is 9600 baud
// R07: Default flow control is RTS/CTS handshaking
// R08: Default format eight data bits, no parity
// R09: Default frame has one stop bit
// R10: Drive low-active RTS, sample low-active CTS
// R11: Transmit enable asserted while character is sent
// R12: Receive nothing before enumeration completes
// R13: Link problem output high until enumerated
// R14: Partner keeps its transmitter off until enumerated
// R15: Only one peripheral function active at once
// R16: Serial function selected by select pins 001
// R17: Deasserted CTS holds off only new characters
`timescale 1ns/1ps
module ubs_port (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic function_select_bit0,
  input wire logic function_select_bit1,
  input wire logic function_select_bit2,
  input wire logic enumerated,
  input wire logic cfg_write,
  input wire logic [19:0] cfg_divisor,
  input wire logic cfg_flow,
  input wire logic cfg_bits8,
  input wire logic cfg_par_en,
  input wire logic cfg_par_odd,
  input wire logic cfg_stop2,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_error,
  output logic port_active,
  output logic link_problem_n,
  output logic uart_txd,
  input wire logic uart_rxd,
  output logic uart_rts_n,
  input wire logic uart_cts_n,
  output logic uart_tx_active
);
  typedef struct packed {
    logic active;
    logic [19:0] div;
    logic flow;
    logic bits8;
    logic par_en;
    logic par_odd;
    logic stop2;
    logic txd;
    logic tx_act;
    logic tx_rdy;
    logic rts_n;
    logic link_n;
    logic rxd_s;
    ubs_pkg::ubs_state_e rst;
    logic [19:0] rcnt;
    logic [2:0] ridx;
    logic [7:0] rsh;
    logic rpar;
    logic [7:0] rdat;
    logic rval;
    logic rerr;
  } ubs_port_s;
  ubs_port_s q, d;
  logic tx_start;
  logic tx_txd;
  logic tx_busy;
  logic rtick;
  logic [2:0] sel;
  assign sel = {function_select_bit2, function_select_bit1,
                function_select_bit0};
  // New character only when idle, active and CTS allows it
  assign tx_start = q.tx_rdy && tx_valid; // R17
  assign rtick = (q.rcnt == 20'h00001);
  ubs_tx u_tx (
    .core_clk(core_clk),
    .reset(reset || !q.active),
    .divisor(q.div),
    .bits8(q.bits8),
    .par_en(q.par_en),
    .par_odd(q.par_odd),
    .stop2(q.stop2),
    .start(tx_start),
    .data(tx_data),
    .txd(tx_txd),
    .busy(tx_busy)
  );
  always_comb begin
    d = q;
    d.rval = 1'b0;
    d.rerr = 1'b0;
    d.active = (sel == ubs_pkg::SEL_SERIAL); // R15 R16
    d.link_n = !enumerated; // R13
    if (cfg_write && q.active) begin // R05
      d.div = (cfg_divisor < ubs_pkg::DIV_MIN) ? ubs_pkg::DIV_MIN :
              (cfg_divisor > ubs_pkg::DIV_MAX) ? ubs_pkg::DIV_MAX :
              cfg_divisor; // R01
      d.flow = cfg_flow;
      d.bits8 = cfg_bits8;
      d.par_en = cfg_par_en;
      d.par_odd = cfg_par_odd;
      d.stop2 = cfg_stop2;
    end
    d.txd = q.active ? tx_txd : 1'b1;
    d.tx_act = q.active && (tx_busy || tx_start); // R11
    d.tx_rdy = q.active && !tx_busy && !tx_start
               && !(q.flow && uart_cts_n); // R10 R17
    d.rts_n = !(q.active && enumerated
                && q.rst == ubs_pkg::UBS_IDLE); // R10
    d.rxd_s = uart_rxd;
    if (q.rst != ubs_pkg::UBS_IDLE) begin
      d.rcnt = rtick ? q.div : q.rcnt - 20'h00001;
    end
    case (q.rst)
      ubs_pkg::UBS_IDLE: begin
        // Receiver stays shut until the link is up
        if (q.active && enumerated && !q.rxd_s) begin // R12
          d.rst = ubs_pkg::UBS_START;
          d.rcnt = {1'b0, q.div[19:1]};
          d.rpar = q.par_odd;
        end
      end
      ubs_pkg::UBS_START: begin
        if (rtick) begin
          if (q.rxd_s) begin
            d.rst = ubs_pkg::UBS_IDLE;
          end else begin
            d.rst = ubs_pkg::UBS_DATA;
            d.ridx = 3'h0;
          end
        end
      end
      ubs_pkg::UBS_DATA: begin
        if (rtick) begin
          d.rsh = q.bits8 ? {q.rxd_s, q.rsh[7:1]}
                          : {1'b0, q.rxd_s, q.rsh[6:1]}; // R02
          d.rpar = q.rpar ^ q.rxd_s;
          d.ridx = q.ridx + 3'h1;
          if (q.ridx == (q.bits8 ? 3'h7 : 3'h6)) begin
            d.rst = q.par_en ? ubs_pkg::UBS_PAR : ubs_pkg::UBS_STOP;
          end
        end
      end
      ubs_pkg::UBS_PAR: begin
        if (rtick) begin
          d.rpar = q.rpar ^ q.rxd_s;
          d.rst = ubs_pkg::UBS_STOP;
        end
      end
      ubs_pkg::UBS_STOP: begin
        if (rtick) begin
          d.rst = ubs_pkg::UBS_IDLE;
          d.rdat = q.rsh;
          d.rval = 1'b1;
          d.rerr = !q.rxd_s || q.rpar; // R03
        end
      end
      default: d.rst = ubs_pkg::UBS_IDLE;
    endcase
    if (!q.active) begin
      d.rst = ubs_pkg::UBS_IDLE;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      q <= '{active: 1'b0, div: ubs_pkg::DIV_DEF, // R06
             flow: ubs_pkg::FLOW_DEF, // R07
             bits8: ubs_pkg::BITS8_DEF, // R08
             par_en: ubs_pkg::PAR_EN_DEF,
             par_odd: ubs_pkg::PAR_ODD_DEF,
             stop2: ubs_pkg::STOP2_DEF, // R09
             txd: 1'b1, tx_act: 1'b0, tx_rdy: 1'b0, rts_n: 1'b1,
             link_n: 1'b1, rxd_s: 1'b1, rst: ubs_pkg::UBS_IDLE,
             rcnt: 20'h00000, ridx: 3'h0, rsh: 8'h00, rpar: 1'b0,
             rdat: 8'h00, rval: 1'b0, rerr: 1'b0};
    end else begin
      q <= d;
    end
  end
  assign tx_ready = q.tx_rdy;
  assign rx_data = q.rdat;
  assign rx_valid = q.rval;
  assign rx_error = q.rerr;
  assign port_active = q.active;
  assign link_problem_n = q.link_n;
  assign uart_txd = q.txd;
  assign uart_rts_n = q.rts_n;
  assign uart_tx_active = q.tx_act;
endmodule

// ==== core/ubs_tx.sv ====
// Serial transmitter: shifts one character out per request
`timescale 1ns/1ps
module ubs_tx (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [19:0] divisor,
  input wire logic bits8,
  input wire logic par_en,
  input wire logic par_odd,
  input wire logic stop2,
  input wire logic start,
  input wire logic [7:0] data,
  output logic txd,
  output logic busy
);
  typedef struct packed {
    ubs_pkg::ubs_state_e st;
    logic [19:0] cnt;
    logic [2:0] idx;
    logic [7:0] sh;
    logic par;
    logic stop_n;
    logic txd;
  } ubs_tx_s;
  ubs_tx_s q, d;
  logic tick;
  assign tick = (q.cnt == 20'h00001);
  always_comb begin
    d = q;
    if (q.st != ubs_pkg::UBS_IDLE) begin
      d.cnt = tick ? divisor : q.cnt - 20'h00001;
    end
    case (q.st)
      ubs_pkg::UBS_IDLE: begin
        d.txd = 1'b1;
        if (start) begin
          d.st = ubs_pkg::UBS_START;
          d.sh = data;
          d.par = par_odd;
          d.cnt = divisor;
          d.txd = 1'b0; // R02
        end
      end
      ubs_pkg::UBS_START: begin
        if (tick) begin
          d.st = ubs_pkg::UBS_DATA;
          d.idx = 3'h0;
          d.txd = q.sh[0]; // R04
        end
      end
      ubs_pkg::UBS_DATA: begin
        if (tick) begin
          d.par = q.par ^ q.sh[0];
          d.sh = {1'b0, q.sh[7:1]}; // R04
          d.idx = q.idx + 3'h1;
          if (q.idx == (bits8 ? 3'h7 : 3'h6)) begin // R02
            if (par_en) begin
              d.st = ubs_pkg::UBS_PAR;
              d.txd = q.par ^ q.sh[0];
            end else begin
              d.st = ubs_pkg::UBS_STOP;
              d.stop_n = stop2;
              d.txd = 1'b1;
            end
          end else begin
            d.txd = q.sh[1];
          end
        end
      end
      ubs_pkg::UBS_PAR: begin
        if (tick) begin
          d.st = ubs_pkg::UBS_STOP;
          d.stop_n = stop2;
          d.txd = 1'b1;
        end
      end
      ubs_pkg::UBS_STOP: begin
        if (tick) begin
          if (q.stop_n) begin
            d.stop_n = 1'b0; // R03
          end else begin
            d.st = ubs_pkg::UBS_IDLE;
          end
        end
      end
      default: d.st = ubs_pkg::UBS_IDLE;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      q <= '{st: ubs_pkg::UBS_IDLE, cnt: 20'h00000, idx: 3'h0,
             sh: 8'h00, par: 1'b0, stop_n: 1'b0, txd: 1'b1};
    end else begin
      q <= d;
    end
  end
  assign txd = q.txd;
  assign busy = (q.st != ubs_pkg::UBS_IDLE);
endmodule

// ==== dv/test_usb_bridged_serial_port.sv ====
// Self-checking bench for the bridged serial port
`timescale 1ns/1ps
module test_usb_bridged_serial_port;
  logic core_clk = 1'b0, reset = 1'b1, enumerated = 1'b0, cfg_write = 1'b0;
  logic function_select_bit0 = 1'b1, function_select_bit1 = 1'b0;
  logic function_select_bit2 = 1'b0, cfg_flow = 1'b1, cfg_bits8 = 1'b1;
  logic cfg_par_en = 1'b0, cfg_par_odd = 1'b0, cfg_stop2 = 1'b0;
  logic [19:0] cfg_divisor = 20'h01046;
  logic tx_valid = 1'b0, tx_ready, rx_valid, rx_error, port_active;
  logic [7:0] tx_data = 8'h00, rx_data;
  logic link_problem_n, uart_txd, uart_rxd, uart_rts_n, uart_cts_n;
  logic uart_tx_active;
  int error_cnt = 0, cmp_count = 0, cycles = 0;
  ubs_port u_dut (.*);
  ubs_dev u_dev (.core_clk, .txd(uart_txd), .rts_n(uart_rts_n),
    .rxd(uart_rxd), .cts_n(uart_cts_n));
  initial forever #12.5 core_clk = ~core_clk;
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      tally_and_finish;
    end
  end
  task automatic chk(input logic [9:0] s, e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic put(input logic [7:0] d, input int nb, dv, p, ns, e);
    logic [9:0] v;
    fork
      u_dev.get(v, nb, dv, p, ns);
      begin
        tx_valid <= 1'b1;
        tx_data <= d;
        // Look at ready between edges so the taking edge is the next one
        do @(negedge core_clk); while (tx_ready !== 1'b1);
        @(posedge core_clk);
        tx_valid <= 1'b0;
      end
    join
    chk(v, e[9:0]);
  endtask
  task automatic rcv(input logic [7:0] d, input int p, e);
    logic [9:0] v;
    v = 10'h3FF;
    fork
      u_dev.send(d, 7, 40, p, 1);
      begin
        // Error flag is a one-cycle pulse: capture it with the strobe
        for (int n = 0; n < 800 && rx_valid !== 1'b1; n++) begin
          @(negedge core_clk);
        end
        v = {rx_error, rx_data};
      end
    join
    chk(v, e[9:0]);
  endtask
  initial begin
    cyc(8);
    reset <= 1'b0;
    cyc(3);
    chk(link_problem_n, 1'b1);
    chk(uart_rts_n, 1'b1);
    put(8'hA5, 8, 4166, -1, 1, 10'h2A5);
    $display("defaults done");
    {cfg_divisor, cfg_bits8, cfg_par_en, cfg_par_odd, cfg_stop2} <=
      {20'h00028, 4'h7};
    cfg_write <= 1'b1;
    cyc(1);
    cfg_write <= 1'b0;
    cyc(2);
    put(8'hC3, 7, 40, 0, 2, 10'h243);
    put(8'h7E, 7, 40, 0, 2, 10'h37E);
    $display("format done");
    u_dev.hold(1'b1);
    // Ready is registered: let the held-off state reach it first
    cyc(2);
    tx_valid <= 1'b1;
    cyc(40);
    chk(uart_tx_active, 1'b0);
    chk(tx_ready, 1'b0);
    u_dev.hold(1'b0);
    put(8'h11, 7, 40, 0, 2, 10'h311);
    $display("flow done");
    enumerated <= 1'b1;
    cyc(3);
    chk(link_problem_n, 1'b0);
    chk(uart_rts_n, 1'b0);
    rcv(8'h35, 1, 10'h035);
    rcv(8'h35, 0, 10'h135);
    $display("receive done");
    function_select_bit1 <= 1'b1;
    cyc(3);
    chk({port_active, uart_txd}, 2'h1);
    function_select_bit1 <= 1'b0;
    cyc(3);
    chk(port_active, 1'b1);
    $display("select done");
    tally_and_finish;
  end
endmodule
bind ubs_port ubs_port_props u_props (.*);

// ==== dv/ubs_dev.sv ====
// Far-side serial device model
`timescale 1ns/1ps
module ubs_dev (
  input wire logic core_clk,
  input wire logic txd,
  input wire logic rts_n,
  output logic rxd,
  output logic cts_n
);
  initial begin
    rxd = 1'b1;
    cts_n = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic hold(input logic h);
    @(posedge core_clk);
    cts_n <= h;
  endtask
  // Parity argument below zero means no parity bit
  task automatic send(input logic [7:0] d, input int nb, div, par, ns);
    wait (!rts_n);
    @(posedge core_clk);
    rxd <= 1'b0;
    wt(div);
    for (int i = 0; i < nb; i++) begin
      rxd <= d[i];
      wt(div);
    end
    if (par >= 0) begin
      rxd <= par[0];
      wt(div);
    end
    rxd <= 1'b1;
    wt(div * ns);
  endtask
  // Returns stops-ok, parity and data sampled at mid-bit
  task automatic get(output logic [9:0] v, input int nb, div, par, ns);
    v = 10'h200;
    @(negedge txd);
    wt(div / 2);
    for (int i = 0; i < nb; i++) begin
      wt(div);
      v[i] = txd;
    end
    if (par >= 0) begin
      wt(div);
      v[8] = txd;
    end
    for (int i = 0; i < ns; i++) begin
      wt(div);
      v[9] = v[9] & txd;
    end
  endtask
endmodule

// ==== dv/ubs_port_properties.sv ====
// Port-level properties of the bridged serial port
`timescale 1ns/1ps
module ubs_port_props (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic function_select_bit0,
  input wire logic function_select_bit1,
  input wire logic function_select_bit2,
  input wire logic enumerated,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic port_active,
  input wire logic link_problem_n,
  input wire logic uart_txd,
  input wire logic uart_rts_n,
  input wire logic uart_cts_n,
  input wire logic uart_tx_active
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_take;
    tx_valid && tx_ready;
  endsequence
  sequence s_launch;
    !tx_ready ##1 (!uart_txd && uart_tx_active);
  endsequence
  a_take_walk: assert property (s_take |=> s_launch)
    else $error("character launch late");
  a_link_status: assert property (!$past(reset) |->
    link_problem_n == !$past(enumerated)) else $error("link status wrong");
  a_rts_early: assert property (!$past(enumerated) |-> uart_rts_n)
    else $error("rts low before link up");
  a_rx_early: assert property (!$past(enumerated) |-> !rx_valid)
    else $error("data received before link up");
  // Flow control is never switched off in this bench
  a_cts_hold: assert property (uart_cts_n [*6] |-> !$rose(uart_tx_active))
    else $error("character started while held off");
  a_txd_frame: assert property (!uart_txd |-> uart_tx_active)
    else $error("line low outside a character");
  a_port_sel: assert property (!$past(reset) |-> port_active ==
    ($past({function_select_bit2, function_select_bit1,
    function_select_bit0}) == ubs_pkg::SEL_SERIAL)) else $error("select");
  a_idle_mode: assert property (!port_active && !$past(port_active) |->
    uart_txd && !tx_ready) else $error("inactive port not quiet");
  a_rx_pulse: assert property (rx_valid |=> !rx_valid)
    else $error("receive strobe too long");
endmodule
